// file: rtl/ccg_top.sv
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ccg_top
  import ccg_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  input wire logic clk, // 250 MHz clock
  input wire logic rst_b, // Sync reset, active low
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic wb_we_i, // Write strobe
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic [CNT_W-1:0] count_in, // Running counter value
  input wire logic cap1_pin, // First capture input
  input wire logic hold_pin, // Gate/capture input
  input wire logic index_pin, // Encoder index pulse
  output logic counter_hold // Hold request to counter
);
  import ccg_pkg::*;

  ccg_pins_t meta;
  ccg_pins_t sync;
  ccg_pins_t prev;
  logic [4:0] ctrl;
  logic [3:0] cfg;
  logic [CNT_W-1:0] cap1_val;
  logic [CNT_W-1:0] cap2_val;
  logic c1_valid;
  logic c2_valid;
  logic idx_valid;
  logic idx_done;
  logic grp_locked;

  // Two-flop synchronisers; meta read only by sync
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= {cap1_pin, hold_pin, index_pin};
      sync <= meta;
      prev <= sync;
    end
  end

  // Edge detection from successive samples
  wire c1_rise = sync.cap1 & ~prev.cap1;
  wire c1_fall = ~sync.cap1 & prev.cap1;
  wire c2_rise = sync.hold & ~prev.hold;
  wire c2_fall = ~sync.hold & prev.hold;
  wire idx_rise = sync.index & ~prev.index;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = bus_wr & (wb_adr_i == REG_CTRL);
  wire wr_cfg = bus_wr & (wb_adr_i == REG_CFG);
  wire [4:0] ctrl_d = wr_ctrl ? wb_dat_i[4:0] : ctrl;

  wire c1_armed = ctrl[CTRL_C1_RISE] | ctrl[CTRL_C1_FALL];
  wire c2_armed = ctrl[CTRL_C2_RISE] | ctrl[CTRL_C2_FALL];
  wire c1_cont = cfg[CFG_C1_CONT];
  wire c2_cont = cfg[CFG_C2_CONT];
  wire [1:0] pol = cfg[CFG_POL_LO +: 2];
  // Armed edge match; one decoder shared by both capture inputs
  function automatic logic edge_hit(
    input logic arm_rise, // Rising edge armed
    input logic arm_fall, // Falling edge armed
    input logic seen_rise, // Rising edge this cycle
    input logic seen_fall // Falling edge this cycle
  );
    return (arm_rise & seen_rise) | (arm_fall & seen_fall);
  endfunction : edge_hit

  // Armed edge match, either polarity when both set
  wire c1_edge = edge_hit(ctrl[CTRL_C1_RISE], ctrl[CTRL_C1_FALL],
    c1_rise, c1_fall);
  wire c2_edge = edge_hit(ctrl[CTRL_C2_RISE], ctrl[CTRL_C2_FALL],
    c2_rise, c2_fall);
  // Shared-result group: continuous first input racing the index arm
  wire grp_mode = c1_cont & ctrl[CTRL_IDX_ARM];
  wire c1_take = c1_edge & ~grp_locked & (c1_cont ? 1'b1 : ~c1_valid) & ~(grp_mode & idx_done);
  wire idx_take = ctrl[CTRL_IDX_ARM] & idx_rise & ~idx_done & ~grp_locked & ~c1_take;
  wire c2_take = c2_edge & (c2_cont ? 1'b1 : ~c2_valid);
  // Hold level per polarity; capture is taken from the pre-hold count
  wire next_hold = (pol == POL_HIGH) ? sync.hold : (pol == POL_LOW) ? ~sync.hold : 1'b0;

  // Control and config registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl <= '0;
      cfg <= '0;
    end
    else
    begin
      ctrl <= ctrl_d;
      if (wr_cfg)
        cfg <= wb_dat_i[3:0];
    end
  end

  // First result and its flags
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cap1_val <= '0;
      c1_valid <= 1'b0;
      idx_valid <= 1'b0;
      idx_done <= 1'b0;
      grp_locked <= 1'b0;
    end
    else
    begin
      if (c1_take | idx_take)
        cap1_val <= count_in;
      // Valid set wins; cleared when arms drop
      c1_valid <= c1_take | (c1_valid & c1_armed);
      idx_valid <= idx_take | (idx_valid & ctrl[CTRL_IDX_ARM]);
      // Index accepts again only once arm and flag are both low
      idx_done <= idx_take | (idx_done & (ctrl[CTRL_IDX_ARM] | idx_valid));
      grp_locked <= (grp_mode & (c1_take | idx_take))
        | (grp_locked & (c1_armed | ctrl[CTRL_IDX_ARM]));
    end
  end

  // Second result; capture and hold land on one edge, so the stored count is pre-hold
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cap2_val <= '0;
      c2_valid <= 1'b0;
      counter_hold <= 1'b0;
    end
    else
    begin
      if (c2_take)
        cap2_val <= count_in;
      c2_valid <= c2_take | (c2_valid & c2_armed);
      counter_hold <= next_hold;
    end
  end

  // Read mux; status shows live levels
  wire [31:0] stat_word = {26'h0, counter_hold, sync.hold, sync.cap1,
    c2_valid, c1_valid, idx_valid};
  wire [31:0] rd_word =
    (wb_adr_i == REG_CTRL) ? {27'h0, ctrl} :
    (wb_adr_i == REG_CFG) ? {28'h0, cfg} :
    (wb_adr_i == REG_STAT) ? stat_word :
    (wb_adr_i == REG_CAP1) ? 32'(cap1_val) :
    (wb_adr_i == REG_CAP2) ? 32'(cap2_val) : 32'h0;

  // One-cycle ack; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_word;
    end
  end

  // Assertions
  // Single mode keeps the first result; index capture may still share it
  single_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (c1_valid & c1_armed & ~c1_cont & ~idx_take & ~wr_ctrl & ~wr_cfg) |=> $stable(cap1_val))
    else $error("first result changed in single mode");

  // First capture lands with its flag
  cap1_valid_a: assert property (@(posedge clk) disable iff (!rst_b)
    c1_take |=> (c1_valid && cap1_val == $past(count_in)))
    else $error("first capture not confirmed");

  // Second capture lands with its flag
  cap2_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    c2_take |=> (c2_valid && cap2_val == $past(count_in)))
    else $error("second capture not stored");

  // Continuous second capture on every armed edge
  cont2_each_a: assert property (@(posedge clk) disable iff (!rst_b)
    (c2_cont & c2_edge) |=> (c2_valid && cap2_val == $past(count_in)))
    else $error("continuous second capture missed");

  // Later index pulses leave the first result alone
  idx_once_a: assert property (@(posedge clk) disable iff (!rst_b)
    (idx_done && idx_rise && !c1_take) |=> $stable(cap1_val))
    else $error("index captured twice");

  // Disabled polarity never holds the counter
  hold_pol_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pol == POL_OFF) |=> ##1 (~counter_hold || $past(pol) != POL_OFF))
    else $error("hold with gate disabled");

  // High polarity holds once the input is high
  hold_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pol == POL_HIGH && $rose(sync.hold)) |=> counter_hold)
    else $error("high hold not applied");

  // Status shows the first input level
  level_rpt_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wb_ack_o && $past(wb_adr_i) == REG_STAT) |-> wb_dat_o[STAT_C1_LEVEL] == $past(sync.cap1))
    else $error("input level misreported");

  // Locked group ignores every later event
  grp_first_a: assert property (@(posedge clk) disable iff (!rst_b)
    (grp_locked && (c1_edge || idx_rise)) |=> $stable(cap1_val))
    else $error("later event stored after first");

  // First stored event locks the group
  grp_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
    (grp_mode && (c1_take || idx_take)) |=> grp_locked)
    else $error("group not locked by first event");

  // Armed rising edge with flag clear captures
  rise1_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl[CTRL_C1_RISE] && c1_rise && !c1_valid && !grp_locked && !(grp_mode && idx_done))
    |=> (cap1_val == $past(count_in)))
    else $error("rising edge capture missed");

  // Armed falling edge with flag clear captures
  fall1_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl[CTRL_C1_FALL] && c1_fall && !c1_valid && !grp_locked && !(grp_mode && idx_done))
    |=> (cap1_val == $past(count_in)))
    else $error("falling edge capture missed");

  // Both arms take either edge
  both1_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl[CTRL_C1_RISE] && ctrl[CTRL_C1_FALL] && (c1_rise || c1_fall) && !c1_valid
      && !grp_locked && !grp_mode) |=> c1_valid)
    else $error("either edge capture missed");

  // Continuous first input overwrites, outside a locked group
  cont1_each_a: assert property (@(posedge clk) disable iff (!rst_b)
    (c1_cont && c1_edge && !grp_mode && !grp_locked) |=> (cap1_val == $past(count_in)))
    else $error("continuous first capture missed");

  // Dropping all first arms clears the flag
  valid1_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    !c1_armed |=> !c1_valid)
    else $error("first flag stuck after disarm");

  // Dropping all gate arms clears the flag
  valid2_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    !c2_armed |=> !c2_valid)
    else $error("second flag stuck after disarm");

  // Single mode keeps the second result
  single2_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (c2_valid && !c2_cont && !wr_cfg) |=> $stable(cap2_val))
    else $error("second result changed in single mode");

  // Both gate arms take either edge
  both2_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ctrl[CTRL_C2_RISE] && ctrl[CTRL_C2_FALL] && (c2_rise || c2_fall) && !c2_valid)
    |=> (c2_valid && cap2_val == $past(count_in)))
    else $error("either gate edge capture missed");

  // Index capture lands with its flag
  idx_valid_a: assert property (@(posedge clk) disable iff (!rst_b)
    idx_take |=> (idx_valid && cap1_val == $past(count_in)))
    else $error("index capture not confirmed");

  // Index stays spent while its flag is up
  idx_rearm_a: assert property (@(posedge clk) disable iff (!rst_b)
    (idx_done && idx_valid) |=> idx_done)
    else $error("index rearmed too early");

  // Low hold: pre-hold count stored, then held
  low_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pol == POL_LOW && ctrl[CTRL_C2_FALL] && c2_fall && !c2_valid)
    |=> (c2_valid && cap2_val == $past(count_in) && counter_hold))
    else $error("low hold capture order wrong");

  // High hold: pre-hold count stored, then held
  high_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pol == POL_HIGH && ctrl[CTRL_C2_RISE] && c2_rise && !c2_valid)
    |=> (c2_valid && cap2_val == $past(count_in) && counter_hold))
    else $error("high hold capture order wrong");

  // Low polarity holds once the input is low
  hold_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pol == POL_LOW && $fell(sync.hold)) |=> counter_hold)
    else $error("low hold not applied");

  // Status shows the gate input level
  gate_rpt_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wb_ack_o && $past(wb_adr_i) == REG_STAT) |-> wb_dat_o[STAT_HOLD_LEVEL] == $past(sync.hold))
    else $error("gate level misreported");

  // Edge history is the previous synchronised sample
  sync_chain_a: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |-> (prev == $past(sync)))
    else $error("edge history out of step");

  // Acknowledge is a single pulse
  ack_once_a: assert property (@(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  // Main scenarios
  c1_cov_c: cover property (@(posedge clk) disable iff (!rst_b) c1_take);
  hold_cov_c: cover property (@(posedge clk) disable iff (!rst_b) pol == POL_LOW && counter_hold);
  c2_cov_c: cover property (@(posedge clk) disable iff (!rst_b) c2_take ##1 counter_hold);
  idx_cov_c: cover property (@(posedge clk) disable iff (!rst_b) idx_take);
  grp_cov_c: cover property (@(posedge clk) disable iff (!rst_b) grp_mode & idx_take);
endmodule : ccg_top
`default_nettype wire

// file: rtl/ccg_pkg.sv
package ccg_pkg;
  // Wishbone register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_CAP1 = 8'h0c;
  localparam logic [7:0] REG_CAP2 = 8'h10;
  // Control bit positions
  localparam int CTRL_IDX_ARM = 0;
  localparam int CTRL_C1_RISE = 1;
  localparam int CTRL_C1_FALL = 2;
  localparam int CTRL_C2_RISE = 3;
  localparam int CTRL_C2_FALL = 4;
  // Config bit positions
  localparam int CFG_POL_LO = 0;
  localparam int CFG_C1_CONT = 2;
  localparam int CFG_C2_CONT = 3;
  // Status bit positions
  localparam int STAT_IDX_VALID = 0;
  localparam int STAT_C1_VALID = 1;
  localparam int STAT_C2_VALID = 2;
  localparam int STAT_C1_LEVEL = 3;
  localparam int STAT_HOLD_LEVEL = 4;
  localparam int STAT_HOLDING = 5;
  // Hold polarity encodings
  localparam logic [1:0] POL_OFF = 2'h0;
  localparam logic [1:0] POL_HIGH = 2'h1;
  localparam logic [1:0] POL_LOW = 2'h2;
  // Synchronised input sample
  typedef struct packed {
    logic cap1;
    logic hold;
    logic index;
  } ccg_pins_t;
endpackage : ccg_pkg

// file: verif/ccg_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// Switches and encoder: counter value and trigger pin levels
module ccg_far_model
(
  output logic [31:0] count_in, // Counter value fed to the block
  output ccg_pkg::ccg_pins_t pins // First capture, gate, index levels
);
  // Open switches at power-up, so no false edge leaves reset
  initial
  begin
    count_in = 32'h0;
    pins = 3'h0;
  end
  // Called just after a clock edge, so pins never move at a sampling point
  task automatic drive(input logic [31:0] c, input logic [2:0] p);
    count_in <= c;
    pins <= p;
  endtask : drive
endmodule : ccg_far_model
`default_nettype wire

// file: verif/counter_capture_and_gate_test.sv
`timescale 1ns/100ps
`default_nettype none
module counter_capture_and_gate_test;
  import ccg_pkg::*;
  logic clk, rst_b, cyc, stb, we, ack, hold;
  logic [7:0] adr;
  logic [31:0] dat, q, rd, cnt, a, b, e2;
  ccg_pins_t pins;
  int failures, comparisons, cycles, seed;
  ccg_far_model far_u (.count_in(cnt), .pins(pins));
  ccg_top dut_u (.clk(clk), .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(q), .wb_ack_o(ack),
    .count_in(cnt), .cap1_pin(pins.cap1), .hold_pin(pins.hold), .index_pin(pins.index),
    .counter_hold(hold));
  // 4 ns clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk)
    if (++cycles == 5000)
    begin
      failures++;
      tally_and_finish();
    end
  task automatic tally_and_finish();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Classic cycle: hold the request until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'h3, w, ad, d};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = q;
    {cyc, stb} <= 2'h0;
  endtask : bus
  task automatic look(input logic [7:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask : look
  // Six cycles covers sync, detect and hold latency
  task automatic step(input logic [31:0] c, input logic [2:0] p);
    @(posedge clk);
    far_u.drive(c, p);
    repeat (6) @(posedge clk);
  endtask : step
  // Main sequence; expected values come from the model variables a, b, e2
  initial
  begin
    seed = 32'h9d92178a;
    {rst_b, cyc, stb, we, adr, dat} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    look(REG_STAT, 32'h0);
    look(8'h14, 32'h0);
    bus(1'b1, REG_STAT, 32'hff);
    look(REG_STAT, 32'h0);
    bus(1'b1, REG_CFG, 32'h0);
    // Every arm mix on both inputs, single mode: later edges must not overwrite
    for (int ch = 0; ch < 2; ch++)
      for (int m = 1; m < 4; m++)
      begin
        a = $random(seed);
        b = $random(seed);
        bus(1'b1, REG_CTRL, 32'h0);
        bus(1'b1, REG_CTRL, 32'(m) << (ch ? 3 : 1));
        step(a, ch ? 3'h2 : 3'h4);
        look(REG_STAT, (32'(m % 2) << (1 + ch)) | (32'h8 << ch));
        step(b, 3'h0);
        step($random(seed), ch ? 3'h2 : 3'h4);
        step(cnt, 3'h0);
        look(ch ? REG_CAP2 : REG_CAP1, m % 2 ? a : b);
      end
    // Continuous length measurement twice, no re-arming
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_CFG, 32'hc);
    bus(1'b1, REG_CTRL, 32'h12);
    repeat (2)
    begin
      a = $random(seed);
      b = $random(seed);
      step(a, 3'h4);
      step($random(seed), 3'h2);
      step(b, 3'h0);
    end
    look(REG_CAP1, a);
    look(REG_CAP2, b);
    e2 = b;
    // Index grouped with continuous first input: first event locks the result
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_CFG, 32'h4);
    bus(1'b1, REG_CTRL, 32'h3);
    a = $random(seed);
    step(a, 3'h1);
    step($random(seed), 3'h4);
    look(REG_STAT, 32'h9);
    bus(1'b1, REG_CTRL, 32'h1);
    step($random(seed), 3'h0);
    step($random(seed), 3'h1);
    look(REG_CAP1, a);
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_CTRL, 32'h1);
    b = $random(seed);
    step($random(seed), 3'h0);
    step(b, 3'h1);
    look(REG_CAP1, b);
    // Polarity sweep with both gate edges capturing continuously
    bus(1'b1, REG_CTRL, 32'h18);
    for (int p = 0; p < 3; p++)
      for (int l = 0; l < 2; l++)
      begin
        a = $random(seed);
        bus(1'b1, REG_CFG, 32'h8 | 32'(p));
        step(a, l ? 3'h3 : 3'h1);
        e2 = (l == 1 || p > 0) ? a : e2;
        look(REG_CAP2, e2);
        chk(32'(hold), 32'(p == 1 && l == 1 || p == 2 && l == 0));
      end
    tally_and_finish();
  end
endmodule : counter_capture_and_gate_test
`default_nettype wire
